// [design/dvct_pkg.sv]
// Package for the dynamic voltage code tracker: timing, widths and carrier types.
// Assumes a single 40 MHz system clock; all slower rates are enables derived from it.
package dvct_pkg;
   // System clock in kHz.
   localparam int CLK_KHZ = 40000;
   // Sampling clock and stepping tick rates in kHz.
   localparam int SAMPLE_KHZ = 3000;
   localparam int STEP_KHZ = 330;
   // Cycles per sample and per step tick (rounded down, a rate is a longest time).
   localparam int SAMPLE_DIV = CLK_KHZ / SAMPLE_KHZ;
   localparam int STEP_DIV = CLK_KHZ / STEP_KHZ;
   // Equal samples needed before a new code is accepted.
   localparam int QUAL_COUNT = 3;
   // Width of the voltage code.
   localparam int CODE_W = 8;
   // Reference code after reset.
   localparam logic [CODE_W-1:0] REF_RESET = 8'h00;
   // Mode of tracking behaviour.
   typedef enum logic {DVCT_MODE_STEP, DVCT_MODE_SLEW} dvct_mode_t;
   // Status carried out of the block.
   typedef struct packed {
      logic ramping;
      logic accepted;
   } dvct_stat_t;
endpackage

// [design/dvct_rate_div.sv]
// Enable divider: emits a one-cycle pulse every DIV cycles.
// Assumes the single system clock and asynchronous active-low reset.
module dvct_rate_div #(
   parameter int DIV = 13
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Output enable pulse.
   output logic tick
);
   localparam int CW = $clog2(DIV + 1);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic wrap;

   // Elaboration check: a divide by one would leave the pulse stuck high.
   if (DIV < 2) begin
      $error("DIV must be at least 2");
   end

   // Wrap decode and next count.
   assign wrap = (cnt_r == CW'(DIV - 1));
   assign cnt_nxt = wrap ? '0 : cnt_r + 1'b1;

   // Free-running counter; the pulse is registered so it is glitch-free.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick <= wrap;
      end
   end
endmodule

// [design/dvct_tracker.sv]
// Dynamic voltage code tracker: qualifies processor voltage codes and drives the DAC reference code.
// Assumes the code inputs and mode are synchronous to clk, and the block is reset at power-on.
// Overview of operation
// - Step-tracking: sample the voltage code inputs on each 3 MHz sampling tick.
// - Accept a changed code only after three equal consecutive samples; mismatch restarts.
// - Step-tracking: load the accepted code into the reference at once.
// - Slewing: same 3 MHz sampling and identical three-sample qualification.
// - Slewing: multi-step code jumps are accepted as valid requests.
// - Slewing: move reference one step per 330 kHz tick until equal to target.
module dvct_tracker
   import dvct_pkg::*;
#(
   parameter int CODE_WIDTH = CODE_W,
   parameter int QUAL = QUAL_COUNT
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Processor code inputs and mode selection.
   input wire logic [CODE_WIDTH-1:0] voltage_code_inputs,
   input wire dvct_mode_t mode,
   // Reference code to the DAC and status.
   output logic [CODE_WIDTH-1:0] ref_code,
   output logic [CODE_WIDTH-1:0] target_code,
   output dvct_stat_t stat
);
   localparam int QW = $clog2(QUAL + 1);

   // Timing in short: the code is sampled once per sampling tick, and a new value is
   // taken after QUAL equal samples, so acceptance lands two to three sample periods
   // after the processor moves the code. In step mode the reference follows the target
   // in the same clock; in slew mode it walks one code per stepping tick. The stepping
   // divider runs free, so the first step of a ramp can come anywhere within one step
   // period after acceptance; a fixed phase was traded for a simpler divider.
   // A code that returns to the current target is never counted as a new request.

   // Elaboration checks: the run counter needs room for QUAL, and a code must have bits.
   if (QUAL < 2) begin
      $error("QUAL must be at least 2");
   end
   if (CODE_WIDTH < 1) begin
      $error("CODE_WIDTH must be positive");
   end

   logic sample_tick;
   logic step_tick;
   logic [CODE_WIDTH-1:0] cand_r;
   logic [QW-1:0] qcnt_r;
   logic [QW-1:0] qcnt_nxt;
   logic [CODE_WIDTH-1:0] cand_nxt;
   logic same_sample;
   logic new_code;
   logic accept;
   logic [CODE_WIDTH-1:0] ref_nxt;
   logic [CODE_WIDTH-1:0] target_nxt;
   logic ref_below;
   logic ref_above;
   logic slewing;

   dvct_rate_div #(.DIV(SAMPLE_DIV)) u_sample_div (
      .clk(clk),
      .rst_b(rst_b),
      .tick(sample_tick)
   );

   dvct_rate_div #(.DIV(STEP_DIV)) u_step_div (
      .clk(clk),
      .rst_b(rst_b),
      .tick(step_tick)
   );

   // Stability qualification: a sample equal to the candidate extends the run
   // any other sample restarts it with a count of one. Sampling is common to both modes.
   assign same_sample = (voltage_code_inputs == cand_r);
   assign new_code = (cand_r != target_code);
   assign cand_nxt = voltage_code_inputs;
   assign qcnt_nxt = !same_sample ? QW'(1) : (qcnt_r == QW'(QUAL)) ? qcnt_r : qcnt_r + 1'b1;
   // Acceptance does not depend on the size of the jump.
   assign accept = sample_tick && same_sample && new_code && (qcnt_r == QW'(QUAL - 1));

   // Candidate and run length advance only on sampling ticks.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cand_r <= CODE_WIDTH'(REF_RESET);
         qcnt_r <= QW'(QUAL);
      end else if (sample_tick) begin
         cand_r <= cand_nxt;
         qcnt_r <= qcnt_nxt;
      end
   end

   // Direction of the remaining ramp.
   assign ref_below = (ref_code < target_code);
   assign ref_above = (ref_code > target_code);
   assign slewing = (mode == DVCT_MODE_SLEW);
   // A newer accepted code replaces the target, even in the middle of a ramp.
   assign target_nxt = accept ? cand_r : target_code;

   // Step mode jumps to the accepted code; slew mode walks one code per tick.
   // A mode change mid-ramp in step mode snaps to the target, which avoids a stuck ramp.
   always_comb begin
      ref_nxt = ref_code;
      if (!slewing) begin
         ref_nxt = target_nxt;
      end else if (step_tick && ref_below) begin
         ref_nxt = ref_code + 1'b1;
      end else if (step_tick && ref_above) begin
         ref_nxt = ref_code - 1'b1;
      end
   end

   // Registered reference, target and status.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_code <= CODE_WIDTH'(REF_RESET);
         target_code <= CODE_WIDTH'(REF_RESET);
         stat <= '0;
      end else begin
         ref_code <= ref_nxt;
         target_code <= target_nxt;
         stat.accepted <= accept;
         stat.ramping <= (ref_nxt != target_nxt);
      end
   end

   // Helper: cycles since the last step tick, to bound slewing moves.
   int unsigned since_step;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         since_step <= 0;
      end else begin
         since_step <= step_tick ? 0 : since_step + 1;
      end
   end

   // Helper: cycles since the last sampling tick, to bound the sampling period.
   int unsigned since_sample;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         since_sample <= 0;
      end else begin
         since_sample <= sample_tick ? 0 : since_sample + 1;
      end
   end

   // Qualification checks.
   AST_ACCEPT_RUN: assert property (@(posedge clk) disable iff (!rst_b)
      accept |-> (voltage_code_inputs == cand_r && qcnt_r == QW'(QUAL - 1) && cand_r != target_code))
      else $error("Code accepted on a mismatching sample");

   AST_ACCEPT_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
      stat.accepted |-> $past(accept))
      else $error("Acceptance flag without an accepted code");

   AST_TARGET_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      !$past(accept) |-> $stable(target_code))
      else $error("Target moved without an accepted code");

   AST_QUAL_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
      !sample_tick |=> ($stable(cand_r) && $stable(qcnt_r)))
      else $error("Qualification advanced outside a sampling tick");

   AST_SAMPLE_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
      since_sample <= SAMPLE_DIV)
      else $error("Sampling tick overdue");

   AST_ACCEPT_TICK: assert property (@(posedge clk) disable iff (!rst_b)
      accept |-> sample_tick)
      else $error("Code accepted outside a sampling tick");

   AST_TARGET_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
      accept |=> (target_code == $past(cand_r)))
      else $error("Accepted code not loaded as target");

   // Reference checks.
   AST_STEP_JUMP: assert property (@(posedge clk) disable iff (!rst_b)
      (accept && mode == DVCT_MODE_STEP) |=> (ref_code == target_code))
      else $error("Step mode did not jump to accepted code");

   AST_STEP_FOLLOW: assert property (@(posedge clk) disable iff (!rst_b)
      ($past(mode) == DVCT_MODE_STEP) |-> (ref_code == target_code))
      else $error("Step mode reference differs from target");

   AST_SLEW_ONE: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == DVCT_MODE_SLEW && $past(mode) == DVCT_MODE_SLEW && ref_code != $past(ref_code))
         |-> (ref_code == $past(ref_code) + 1'b1 || ref_code == $past(ref_code) - 1'b1))
      else $error("Slew moved more than one code");

   AST_SLEW_RATE: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == DVCT_MODE_SLEW && $past(mode) == DVCT_MODE_SLEW && ref_code != $past(ref_code))
         |-> (since_step == 0))
      else $error("Slew step not aligned to stepping tick");

   AST_SLEW_DIR: assert property (@(posedge clk) disable iff (!rst_b)
      (slewing && step_tick && ref_below && !accept) |=> (ref_code == $past(ref_code) + 1'b1))
      else $error("Slew did not move toward target");

   AST_SLEW_DOWN: assert property (@(posedge clk) disable iff (!rst_b)
      (slewing && step_tick && ref_above && !accept) |=> (ref_code == $past(ref_code) - 1'b1))
      else $error("Slew did not move down toward target");

   AST_SLEW_STOP: assert property (@(posedge clk) disable iff (!rst_b)
      (slewing && ref_code == target_code && !accept) |=> $stable(ref_code))
      else $error("Slew moved past an equal target");

   AST_RAMP_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
      stat.ramping == (ref_code != target_code))
      else $error("Ramping flag disagrees with reference and target");

   // Qualification restart and tick spacing checks.
   AST_QUAL_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
      (sample_tick && !same_sample) |=> (qcnt_r == QW'(1)))
      else $error("Mismatch did not restart qualification");

   AST_STEP_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
      since_step <= STEP_DIV)
      else $error("Stepping tick overdue");
endmodule

// [bench/dvct_proc_model.sv]
// Processor-side model that drives the voltage code inputs of the tracker.
// Assumes the bench names the wanted code; the model applies it on a falling clock edge.
module dvct_proc_model
   import dvct_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Code the bench wants applied, and the driven code.
   input wire logic [CODE_W-1:0] want,
   output logic [CODE_W-1:0] voltage_code_inputs
);
   timeunit 1ns;
   timeprecision 1ps;
   // one change per request.
   // The bench spaces requests well apart so the code stands long enough to qualify, except the 10-cycle glitch, which is kept too short.
   always @(negedge clk) begin
      voltage_code_inputs <= want;
   end
endmodule

// [bench/dynamic_voltage_code_tracker_tb.sv]
// Self-checking bench for the tracker: step-tracking, refused glitches, slewing and retargeting.
// Assumes the tracker with default parameters and the processor model beside it.
module dynamic_voltage_code_tracker_tb
   import dvct_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [CODE_W-1:0] want = 8'h00;
   logic [CODE_W-1:0] vci;
   logic [CODE_W-1:0] ref_c;
   logic [CODE_W-1:0] tgt;
   dvct_mode_t mode = DVCT_MODE_STEP;
   dvct_stat_t stat;
   int miscompares = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   dvct_proc_model proc (.clk(clk), .want(want), .voltage_code_inputs(vci));
   dvct_tracker dut (.clk(clk), .rst_b(rst_b), .voltage_code_inputs(vci), .mode(mode),
      .ref_code(ref_c), .target_code(tgt), .stat(stat));
   // Clock at 40 MHz.
   always #12.5 clk = ~clk;
   // Hang guard; the whole run needs about 1350 cycles.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // The model copies the wish on the next falling edge, so it is set after a rising one.
   task automatic set_code(logic [7:0] v);
      @(posedge clk);
      want = v;
   endtask
   // Waits for the acceptance pulse; a bound keeps a lost code from hanging the run.
   task automatic wait_acc(output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (stat.accepted !== 1'b1 && k < 200);
   endtask
   // Follows a ramp to its goal, checking each step size and the spacing of step ticks.
   task automatic follow(logic [7:0] goal, logic [7:0] d);
      logic [7:0] prv;
      int g;
      bit first;
      prv = ref_c;
      g = 0;
      first = 1;
      for (int i = 0; i < 1500 && ref_c !== goal; i++) begin
         @(posedge clk);
         #1;
         g++;
         if (ref_c !== prv) begin
            check("slew step", ref_c - prv, d);
            if (!first) check("tick gap", 8'(g), 8'(STEP_DIV));
            prv = ref_c;
            g = 0;
            first = 0;
         end
      end
      check("ramp end", ref_c, goal);
   endtask
   task automatic step_track();
      set_code(8'h01);
      wait_acc(n);
      check("step latency", 8'(n >= 26 && n <= 45), 8'h01);
      check("step target", tgt, 8'h01);
      check("step ref", ref_c, 8'h01);
      check("step ramping", 8'(stat.ramping), 8'h00);
   endtask
   task automatic glitch_refused();
      set_code(8'h02);
      repeat (10) @(negedge clk);
      set_code(8'h01);
      repeat (80) @(posedge clk);
      #1;
      check("glitch target", tgt, 8'h01);
   endtask
   task automatic slew_ramp();
      @(negedge clk);
      mode = DVCT_MODE_SLEW;
      set_code(8'h05);
      wait_acc(n);
      check("slew latency", 8'(n >= 26 && n <= 45), 8'h01);
      check("slew target", tgt, 8'h05);
      follow(8'h05, 8'h01);
      check("slew settled", 8'(stat.ramping), 8'h00);
   endtask
   task automatic retarget();
      set_code(8'h09);
      wait_acc(n);
      repeat (200) @(posedge clk);
      set_code(8'h03);
      wait_acc(n);
      check("new target", tgt, 8'h03);
      follow(8'h03, 8'hff);
   endtask
   task automatic mid_reset();
      @(negedge clk);
      rst_b = 1'b0;
      repeat (6) @(negedge clk);
      check("reset target", tgt, REF_RESET);
      rst_b = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("restart ref", ref_c, REF_RESET);
   endtask
   // Main sequence: reset for six cycles, then each scenario in turn.
   initial begin
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      check("reset ref", ref_c, REF_RESET);
      step_track();
      glitch_refused();
      slew_ramp();
      retarget();
      mid_reset();
      complete_run();
   end
endmodule
